// [inc/rmc_pkg.sv]
package rmc_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned CFG_BAUD          = 9600;
  localparam logic [15:0] CFG_BIT_CYCLES    = 16'(CLK_HZ / CFG_BAUD);
  localparam int unsigned SETTLE_MS         = 2;
  localparam int unsigned SETTLE_CYCLES_DEF = CLK_HZ / 1000 * SETTLE_MS;
  localparam int unsigned RELOAD_US         = 100;
  localparam int unsigned RELOAD_CYCLES     = CLK_HZ / 1_000_000 * RELOAD_US;
  // bit period per serial rate code, 1200 to 115200 baud
  localparam logic [15:0] DATA_BIT_CYCLES [8] = '{
    16'(CLK_HZ / 1200), 16'(CLK_HZ / 2400), 16'(CLK_HZ / 4800), 16'(CLK_HZ / 9600),
    16'(CLK_HZ / 19200), 16'(CLK_HZ / 38400), 16'(CLK_HZ / 57600), 16'(CLK_HZ / 115200)};

  // ==========================================================================
  // configuration frames
  localparam logic [7:0] HDR_WRITE  = 8'hc0;
  localparam logic [7:0] HDR_READ   = 8'hc1;
  localparam logic [7:0] HDR_TEMP   = 8'hc2;
  localparam logic [7:0] HDR_REMOTE = 8'hcf;
  localparam logic [7:0] HDR_ERROR  = 8'hff;

  // ==========================================================================
  // device configuration registers
  localparam int unsigned REG_UART_IDX   = 3;
  localparam int unsigned UART_SEL_LSB   = 5;
  localparam logic [7:0]  REG_UART_RESET = 8'h60;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  // ==========================================================================
  // controller APB registers
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_TXDATA   = 8'h08;
  localparam logic [7:0] OFS_RXDATA   = 8'h0c;
  localparam logic [7:0] OFS_DIV      = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_EN   = 8'h18;
  localparam logic [7:0] OFS_INT_CLR  = 8'h1c;
  localparam int unsigned INT_RX      = 0;
  localparam int unsigned INT_BUSY    = 1;
  localparam int unsigned INT_TX      = 2;
  localparam int unsigned INT_W       = 3;
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_TX_PEND  = 1;
  localparam int unsigned ST_RX_FULL  = 2;
  localparam int unsigned ST_READY    = 3;
  localparam logic [1:0]  CTRL_RESET  = 2'b00;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'd0,
    MODE_WAKE   = 2'd1,
    MODE_CONFIG = 2'd2,
    MODE_SLEEP  = 2'd3
  } rmc_mode_t;

  typedef enum logic [1:0] {
    PH_RELOAD = 2'b00,
    PH_SETTLE = 2'b01,
    PH_RUN    = 2'b11
  } rmc_phase_t;

  typedef enum logic [2:0] {
    PS_IDLE  = 3'b000,
    PS_CF    = 3'b001,
    PS_HDR   = 3'b011,
    PS_ADDR  = 3'b010,
    PS_LEN   = 3'b110,
    PS_DATA  = 3'b111,
    PS_REPLY = 3'b101
  } rmc_parse_t;

endpackage : rmc_pkg

// [inc/rmc_if.sv]
`timescale 1ns/1ns
interface rmc_if;
  logic mode_select_low;   // mode pin, low bit
  logic mode_select_high;  // mode pin, high bit
  logic busy;              // high when module idle and ready
  logic host_txd;          // serial, controller to module
  logic dev_txd;           // serial, module to controller

  modport device (input mode_select_low, input mode_select_high, input host_txd, output busy, output dev_txd);
  modport host (output mode_select_low, output mode_select_high, output host_txd, input busy, input dev_txd);
endinterface : rmc_if

// [hdl/rmc_uart.sv]
`timescale 1ns/1ns
module rmc_uart (
  input  wire logic        pclk,        // clock
  input  wire logic        presetn,     // async reset, active low
  input  wire logic [15:0] bit_cycles,  // clocks per bit
  input  wire logic        rxd,         // serial in
  output logic             txd,         // serial out
  output logic [7:0]       rx_data,     // received byte
  output logic             rx_valid,    // one-cycle pulse per good byte
  input  wire logic [7:0]  tx_data,     // byte to send
  input  wire logic        tx_valid,    // tx_data offered
  output logic             tx_ready,    // transmitter idle
  output logic             busy         // byte in flight either way
);

  logic        rx_on;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_left;
  logic [9:0]  tx_sh;

  assign tx_ready = (tx_left == 4'h0);
  assign busy     = rx_on || !tx_ready;
  assign txd      = tx_sh[0];

  // ==========================================================================
  // receiver, 8N1, sampled mid-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_on    <= 1'b0;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_sh    <= 8'h00;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_on) begin
        if (!rxd) begin
          rx_on  <= 1'b1;
          rx_cnt <= {1'b0, bit_cycles[15:1]};
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= bit_cycles - 16'h0001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rxd) begin
          rx_on <= 1'b0;
        end else if (rx_bit == 4'h9) begin
          rx_on <= 1'b0;
          if (rxd) begin
            rx_data  <= rx_sh;
            rx_valid <= 1'b1;
          end
        end else if (rx_bit != 4'h0) begin
          rx_sh <= {rxd, rx_sh[7:1]};
        end
      end
    end
  end

  // ==========================================================================
  // transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt  <= 16'h0000;
      tx_left <= 4'h0;
      tx_sh   <= 10'h3ff;
    end else if (tx_valid && tx_ready) begin
      tx_sh   <= {1'b1, tx_data, 1'b0};
      tx_left <= 4'ha;
      tx_cnt  <= bit_cycles - 16'h0001;
    end else if (!tx_ready) begin
      if (tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end else begin
        tx_cnt  <= bit_cycles - 16'h0001;
        tx_left <= tx_left - 4'h1;
        tx_sh   <= {1'b1, tx_sh[9:1]};
      end
    end
  end

endmodule : rmc_uart

// [hdl/rmc_device.sv]
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
module rmc_device import rmc_pkg::*; #(
  parameter int unsigned REG_COUNT     = 8,                 // configuration registers
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYCLES_DEF  // settle time after busy rise
) (
  input  wire logic       pclk,               // system clock, 20 MHz
  input  wire logic       presetn,            // async reset, active low
  rmc_if.device           link,               // pins facing the controller
  output logic [7:0]      radio_tx_data,      // byte for the air
  output logic            radio_tx_valid,     // radio_tx_data offered
  input  wire logic       radio_tx_ready,     // radio takes the byte
  output logic            radio_tx_preamble,  // send wake preamble first
  input  wire logic [7:0] radio_rx_data,      // byte from the air
  input  wire logic       radio_rx_valid,     // radio_rx_data offered
  output logic            radio_rx_ready,     // byte taken for serial out
  output logic            radio_rx_enable     // receiver on
);

  localparam int IW = (REG_COUNT > 1) ? $clog2(REG_COUNT) : 1;

  if (REG_COUNT <= REG_UART_IDX || REG_COUNT > 256) begin : g_chk
    $error("rmc_device: REG_COUNT out of range");
  end
  if (SETTLE_CYCLES < 1) begin : g_chk_settle
    $error("rmc_device: SETTLE_CYCLES must be at least 1");
  end

  rmc_mode_t       mode;
  rmc_mode_t       pin_mode;
  rmc_phase_t      phase;
  rmc_parse_t      pst;
  logic [31:0]     ph_cnt;
  logic [7:0]      work [REG_COUNT];
  logic [7:0]      keep [REG_COUNT];
  logic [7:0]      cmd;
  logic [7:0]      addr;
  logic [7:0]      len;
  logic [7:0]      idx;
  logic            remote;
  logic            err;
  logic [8:0]      out_idx;
  logic [8:0]      last;
  logic [8:0]      rel;
  logic [IW-1:0]   wr_idx;
  logic [IW-1:0]   rd_idx;
  logic [7:0]      rx_byte;
  logic            rx_valid;
  logic [7:0]      rsp_byte;
  logic [7:0]      tx_byte;
  logic            tx_valid;
  logic            tx_ready;
  logic            uart_busy;
  logic [15:0]     bit_cycles;
  logic            running;
  logic            data_mode;
  logic            cfg_mode;
  logic            busy_next;
  logic            is_cmd;

  // ==========================================================================
  // mode selection
  assign pin_mode  = rmc_mode_t'({link.mode_select_high, link.mode_select_low});
  assign running   = (phase == PH_RUN);
  assign data_mode = running && (mode == MODE_NORMAL || mode == MODE_WAKE);
  assign cfg_mode  = running && (mode == MODE_CONFIG);
  // idle only with no byte in flight, offered or just received, no radio byte waiting and no open frame;
  // rx_valid and tx_valid close the one-cycle gaps around the registered busy output
  assign busy_next = (phase != PH_RELOAD) && !uart_busy && !radio_tx_valid && (pst == PS_IDLE) &&
                     !rx_valid && !tx_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.busy <= 1'b0;
    end else begin
      link.busy <= busy_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode   <= MODE_NORMAL;
      phase  <= PH_RELOAD;
      ph_cnt <= 32'(RELOAD_CYCLES);
    end else if (phase != PH_RELOAD && link.busy && pin_mode != mode) begin
      mode <= pin_mode;
      if (mode == MODE_SLEEP) begin
        phase  <= PH_RELOAD;
        ph_cnt <= 32'(RELOAD_CYCLES);
      end else begin
        phase  <= PH_SETTLE;
        ph_cnt <= 32'(SETTLE_CYCLES);
      end
    end else if (phase != PH_RUN) begin
      if (ph_cnt > 32'h1) begin
        ph_cnt <= ph_cnt - 32'h1;
      end else begin
        phase  <= (phase == PH_RELOAD) ? PH_SETTLE : PH_RUN;
        ph_cnt <= 32'(SETTLE_CYCLES);
      end
    end
  end

  // ==========================================================================
  // serial port and radio steering
  assign bit_cycles = (mode == MODE_CONFIG) ? CFG_BIT_CYCLES
                                            : DATA_BIT_CYCLES[work[REG_UART_IDX][7:UART_SEL_LSB]];
  assign tx_valid        = cfg_mode ? (pst == PS_REPLY) : (data_mode && radio_rx_valid);
  assign tx_byte         = cfg_mode ? rsp_byte : radio_rx_data;
  assign radio_rx_ready  = data_mode && tx_ready;
  assign radio_rx_enable = data_mode;

  rmc_uart u_uart (
    .pclk       (pclk),
    .presetn    (presetn),
    .bit_cycles (bit_cycles),
    .rxd        (link.host_txd),
    .txd        (link.dev_txd),
    .rx_data    (rx_byte),
    .rx_valid   (rx_valid),
    .tx_data    (tx_byte),
    .tx_valid   (tx_valid),
    .tx_ready   (tx_ready),
    .busy       (uart_busy)
  );

  // one byte held for the radio, no queue beyond it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      radio_tx_data     <= 8'h00;
      radio_tx_valid    <= 1'b0;
      radio_tx_preamble <= 1'b0;
    end else if (data_mode && rx_valid && (!radio_tx_valid || radio_tx_ready)) begin
      radio_tx_data     <= rx_byte;
      radio_tx_valid    <= 1'b1;
      radio_tx_preamble <= (mode == MODE_WAKE);
    end else if (radio_tx_ready) begin
      radio_tx_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // configuration registers
  assign wr_idx = IW'(addr + idx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        work[i] <= (i == REG_UART_IDX) ? REG_UART_RESET : REG_RESET;
        keep[i] <= (i == REG_UART_IDX) ? REG_UART_RESET : REG_RESET;
      end
    end else if (phase == PH_RELOAD) begin
      work <= keep;
    end else if (cfg_mode && rx_valid && pst == PS_DATA) begin
      work[wr_idx] <= rx_byte;
      if (cmd == HDR_WRITE) begin
        keep[wr_idx] <= rx_byte;
      end
    end
  end

  // ==========================================================================
  // frame parser
  assign is_cmd = (rx_byte == HDR_WRITE) || (rx_byte == HDR_READ) || (rx_byte == HDR_TEMP);
  assign last   = err ? 9'd2 : 9'({1'b0, len} + (remote ? 9'd4 : 9'd2));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst     <= PS_IDLE;
      cmd     <= 8'h00;
      addr    <= 8'h00;
      len     <= 8'h00;
      idx     <= 8'h00;
      remote  <= 1'b0;
      err     <= 1'b0;
      out_idx <= 9'h000;
    end else if (!cfg_mode) begin
      pst    <= PS_IDLE;
      remote <= 1'b0;
      err    <= 1'b0;
    end else begin
      case (pst)
        PS_IDLE, PS_HDR: begin
          if (rx_valid) begin
            if (rx_byte == HDR_REMOTE && pst == PS_IDLE) begin
              pst <= PS_CF;
            end else if (is_cmd) begin
              cmd <= rx_byte;
              pst <= PS_ADDR;
            end else begin
              err <= 1'b1;
              pst <= PS_REPLY;
            end
          end
        end
        PS_CF: begin
          if (rx_valid) begin
            if (rx_byte == HDR_REMOTE) begin
              remote <= 1'b1;
              pst    <= PS_HDR;
            end else begin
              err <= 1'b1;
              pst <= PS_REPLY;
            end
          end
        end
        PS_ADDR: begin
          if (rx_valid) begin
            addr <= rx_byte;
            pst  <= PS_LEN;
          end
        end
        PS_LEN: begin
          if (rx_valid) begin
            len <= rx_byte;
            idx <= 8'h00;
            if (rx_byte == 8'h00 || ({1'b0, addr} + {1'b0, rx_byte}) > 9'(REG_COUNT)) begin
              err <= 1'b1;
              pst <= PS_REPLY;
            end else begin
              pst <= (cmd == HDR_READ) ? PS_REPLY : PS_DATA;
            end
          end
        end
        PS_DATA: begin
          if (rx_valid) begin
            idx <= idx + 8'h01;
            if (idx + 8'h01 == len) begin
              pst <= PS_REPLY;
            end
          end
        end
        PS_REPLY: begin
          if (tx_ready) begin
            if (out_idx == last) begin
              pst     <= PS_IDLE;
              out_idx <= 9'h000;
              err     <= 1'b0;
              remote  <= 1'b0;
            end else begin
              out_idx <= out_idx + 9'h001;
            end
          end
        end
        default: pst <= PS_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // reply byte selection
  assign rel    = out_idx - (remote ? 9'd2 : 9'd0);
  assign rd_idx = IW'({1'b0, addr} + rel - 9'd3);

  always_comb begin
    if (err) begin
      rsp_byte = HDR_ERROR;
    end else if (remote && out_idx < 9'd2) begin
      rsp_byte = HDR_REMOTE;
    end else if (rel == 9'd0) begin
      rsp_byte = HDR_READ;
    end else if (rel == 9'd1) begin
      rsp_byte = addr;
    end else if (rel == 9'd2) begin
      rsp_byte = len;
    end else begin
      rsp_byte = work[rd_idx];
    end
  end

endmodule : rmc_device

// [hdl/rmc_host.sv]
`timescale 1ns/1ns
module rmc_host import rmc_pkg::*; (
  input  wire logic        pclk,     // system clock, 20 MHz
  input  wire logic        presetn,  // async reset, active low
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB access phase
  input  wire logic        pwrite,   // APB write
  input  wire logic [7:0]  paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  output logic [31:0]      prdata,   // APB read data
  output logic             pready,   // APB ready, always high
  output logic             pslverr,  // unmapped address
  output logic             irq,      // level interrupt
  rmc_if.host              link      // pins facing the module
);

  logic [1:0]       ctrl_mode;
  logic [15:0]      div;
  logic [7:0]       tx_byte;
  logic             tx_pend;
  logic             tx_ready;
  logic [7:0]       rx_byte;
  logic             rx_evt;
  logic [7:0]       rx_hold;
  logic             rx_full;
  logic             busy_d;
  logic             link_ready;
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_en;
  logic [INT_W-1:0] ev;
  logic             acc;
  logic             wr;
  logic             mapped;

  // ==========================================================================
  // APB decode, zero wait states
  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == OFS_CTRL) || (paddr == OFS_STATUS) || (paddr == OFS_TXDATA) ||
                   (paddr == OFS_RXDATA) || (paddr == OFS_DIV) || (paddr == OFS_INT_STAT) ||
                   (paddr == OFS_INT_EN) || (paddr == OFS_INT_CLR);
  assign pslverr = acc && !mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:     prdata = {30'h0, ctrl_mode};
      OFS_STATUS:   prdata = {28'h0, link_ready, rx_full, tx_pend, link.busy};
      OFS_RXDATA:   prdata = {24'h0, rx_hold};
      OFS_DIV:      prdata = {16'h0, div};
      OFS_INT_STAT: prdata = {29'h0, int_stat};
      OFS_INT_EN:   prdata = {29'h0, int_en};
      default:      prdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // mode pins and serial port
  assign link.mode_select_low  = ctrl_mode[0];
  assign link.mode_select_high = ctrl_mode[1];

  rmc_uart u_uart (
    .pclk       (pclk),
    .presetn    (presetn),
    .bit_cycles (div),
    .rxd        (link.dev_txd),
    .txd        (link.host_txd),
    .rx_data    (rx_byte),
    .rx_valid   (rx_evt),
    .tx_data    (tx_byte),
    .tx_valid   (tx_pend),
    .tx_ready   (tx_ready),
    .busy       ()
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_mode <= CTRL_RESET;
      div       <= CFG_BIT_CYCLES;
      int_en    <= '0;
    end else if (wr) begin
      if (paddr == OFS_CTRL) ctrl_mode <= pwdata[1:0];
      if (paddr == OFS_DIV && pwdata[15:0] > 16'h0001) div <= pwdata[15:0];
      if (paddr == OFS_INT_EN) int_en <= pwdata[INT_W-1:0];
    end
  end

  // a write while a byte is still pending is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte <= 8'h00;
      tx_pend <= 1'b0;
    end else if (tx_pend && tx_ready) begin
      tx_pend <= 1'b0;
    end else if (wr && paddr == OFS_TXDATA && !tx_pend) begin
      tx_byte <= pwdata[7:0];
      tx_pend <= 1'b1;
    end
  end

  // reading RXDATA frees the holding register; a new byte wins over the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_evt) begin
      rx_hold <= rx_byte;
      rx_full <= 1'b1;
    end else if (acc && !pwrite && paddr == OFS_RXDATA) begin
      rx_full <= 1'b0;
    end
  end

  // ==========================================================================
  // busy edge tracking and interrupts
  assign ev[INT_RX]   = rx_evt;
  assign ev[INT_BUSY] = link.busy && !busy_d;
  assign ev[INT_TX]   = tx_pend && tx_ready;
  assign irq          = |(int_stat & int_en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_d     <= 1'b0;
      link_ready <= 1'b0;
      int_stat   <= '0;
    end else begin
      busy_d <= link.busy;
      if (ev[INT_BUSY]) begin
        link_ready <= 1'b1;
      end else if (wr && paddr == OFS_CTRL) begin
        link_ready <= 1'b0;
      end
      if (wr && paddr == OFS_INT_CLR) begin
        int_stat <= (int_stat & ~pwdata[INT_W-1:0]) | ev;
      end else begin
        int_stat <= int_stat | ev;
      end
    end
  end

endmodule : rmc_host

// [bench/rmc_chk.sv]
`timescale 1ns/1ns
// ======
// link checker
module rmc_chk import rmc_pkg::*; (
  input wire logic pclk,             // clock
  input wire logic presetn,          // reset, active low
  input wire logic mode_select_low,  // mode bit 0
  input wire logic mode_select_high, // mode bit 1
  input wire logic busy,             // module ready
  input wire logic host_txd,         // serial to module
  input wire logic dev_txd           // serial from module
);
  int low_n;
  int txl_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run lengths of busy low and of module serial low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_n <= 0;
      txl_n <= 0;
    end else begin
      low_n <= busy ? 0 : low_n + 1;
      txl_n <= dev_txd ? 0 : txl_n + 1;
    end
  end
  reload_low_a: assert property ($rose(presetn) |-> !busy [*8]) else $error("busy high in reload");
  sleep_exit_a: assert property (busy && $past({mode_select_high, mode_select_low}) == 2'b11
    && {mode_select_high, mode_select_low} != 2'b11 |-> ##[1:3] !busy) else $error("no reload on wake");
  reload_len_a: assert property ($rose(busy) |-> low_n >= RELOAD_CYCLES - 2) else $error("reload short");
  txd_idle_a: assert property (busy |-> dev_txd) else $error("serial out while ready");
  start_busy_a: assert property ($fell(host_txd) |-> ##[0:3] !busy) else $error("busy kept on input");
  bit_len_a: assert property ($rose(dev_txd) |-> txl_n >= CFG_BIT_CYCLES - 3) else $error("bit too short");
  rise_idle_a: assert property ($rose(busy) |-> host_txd && dev_txd) else $error("ready on busy line");
  pins_reset_a: assert property ($rose(presetn) |-> !mode_select_low && !mode_select_high) else $error("pins");
  cover property ($rose(busy));
  cover property ($fell(dev_txd));
  cover property (busy && $fell(mode_select_high));
endmodule : rmc_chk

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench import rmc_pkg::*; ;
  logic        pclk, presetn, psel, penable, pwrite, se, pready, pslverr, irq, rx_valid, rx_ready, rx_en;
  logic        rt_valid, rt_pre, rt_ready;
  logic [7:0]  paddr, rx_data, rt_data;
  logic [31:0] pwdata, prdata, rd;
  int          errors, checked;
  rmc_if rmc_if_i ();
  rmc_host rmc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(rmc_if_i));
  rmc_device #(.SETTLE_CYCLES(50)) rmc_device_i (.pclk(pclk), .presetn(presetn), .link(rmc_if_i),
    .radio_tx_data(rt_data), .radio_tx_valid(rt_valid), .radio_tx_ready(rt_ready), .radio_tx_preamble(rt_pre),
    .radio_rx_data(rx_data),
    .radio_rx_valid(rx_valid), .radio_rx_ready(rx_ready), .radio_rx_enable(rx_en));
  rmc_chk rmc_chk_i (.pclk(pclk), .presetn(presetn), .mode_select_low(rmc_if_i.mode_select_low),
    .mode_select_high(rmc_if_i.mode_select_high), .busy(rmc_if_i.busy), .host_txd(rmc_if_i.host_txd),
    .dev_txd(rmc_if_i.dev_txd));
  always #25 pclk = ~pclk;
  // ======
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_busy(input logic v);
    for (int n = 0; n < 3000 && rmc_if_i.busy !== v; n++) @(posedge pclk);
  endtask : wait_busy
  task automatic get_byte(input logic [7:0] exp);
    rd = '0;
    for (int n = 0; n < 20000 && rd[ST_RX_FULL] !== 1'b1; n++) apb(1'b0, OFS_STATUS, 32'h0);
    apb(1'b0, OFS_RXDATA, 32'h0);
    chk(rd, {24'h0, exp}, "serial byte");
  endtask : get_byte
  // ======
  // scenarios
  task automatic t_start;
    apb(1'b1, OFS_INT_EN, 32'h2);
    apb(1'b0, 8'h20, 32'h0);
    chk(se, 1'b1, "no error on unmapped");
    repeat (100) @(negedge pclk);
    chk(rmc_if_i.busy, 1'b0, "busy high in reload");
    wait_busy(1'b1);
    @(negedge pclk);
    chk(irq, 1'b1, "no irq on ready");
    apb(1'b1, OFS_INT_CLR, 32'h2);
    @(negedge pclk);
    chk(irq, 1'b0, "irq not cleared");
    $display("start test done");
  endtask : t_start
  task automatic t_normal;
    repeat (60) @(posedge pclk);
    chk(rx_en, 1'b1, "receiver off");
    // a host byte travels to the air while an air byte travels to the host
    apb(1'b1, OFS_TXDATA, 32'h3c);
    rx_data  <= 8'ha5;
    rx_valid <= 1'b1;
    @(posedge pclk);
    while (rx_ready !== 1'b1) @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= 8'h5a;
    get_byte(8'ha5);
    repeat (20) @(posedge pclk);
    chk({rt_valid, rt_pre, rt_data}, 10'h23c, "air byte");
    rt_ready <= 1'b1;
    $display("normal test done");
  endtask : t_normal
  task automatic t_sleep;
    apb(1'b1, OFS_CTRL, 32'h3);
    @(negedge pclk);
    chk({rmc_if_i.mode_select_high, rmc_if_i.mode_select_low}, 2'b11, "mode pins");
    // the byte to the host is still in its stop bit, so busy is still low and the new mode is taken only when busy rises
    wait_busy(1'b1);
    repeat (60) @(posedge pclk);
    chk(rx_en, 1'b0, "receiver on in sleep");
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (4) @(negedge pclk);
    chk(rmc_if_i.busy, 1'b0, "no reload on wake");
    wait_busy(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_READY], 1'b1, "ready not flagged");
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_config;
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (60) @(posedge pclk);
    chk(rx_en, 1'b0, "receiver on in config");
    apb(1'b1, OFS_TXDATA, 32'h55);
    repeat (3) get_byte(HDR_ERROR);
    $display("config test done");
  endtask : t_config
  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    {pclk, presetn, psel, penable, pwrite, rx_valid, rt_ready} = '0;
    {paddr, rx_data, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_start;
    t_normal;
    t_sleep;
    t_config;
    final_report;
  end
  initial begin
    #8_000_000;
    errors++;
    final_report;
  end
endmodule : testbench
